// [hw/febp_pkg.sv]
package febp_pkg;

  // ----------------------------------------------------------------------
  // Register map, indexed by word on the plain register port.
  // ----------------------------------------------------------------------
  localparam logic [3:0] FEBP_ADDR_CTRL_ONE  = 4'h0;
  localparam logic [3:0] FEBP_ADDR_CTRL_TWO  = 4'h1;
  localparam logic [3:0] FEBP_ADDR_SEL_LOW   = 4'h2;
  localparam logic [3:0] FEBP_ADDR_SEL_HIGH  = 4'h3;
  localparam logic [3:0] FEBP_ADDR_RAM_EMUL  = 4'h4;

  // ----------------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------------
  localparam int         FEBP_BIT_PROG        = 0;
  localparam int         FEBP_BIT_ERASE       = 1;
  localparam int         FEBP_BIT_SWE_LOW     = 6;
  localparam int         FEBP_BIT_SWE_HIGH    = 7;
  localparam int         FEBP_BIT_RAM_OVL     = 3;
  localparam int         FEBP_BLOCKS          = 12;
  localparam logic [7:0] FEBP_RESET_BYTE      = 8'h00;
  localparam logic [7:0] FEBP_SEL_HIGH_MASK   = 8'h0F;
  localparam logic [7:0] FEBP_CTRL_ONE_MASK   = 8'hC3;
  localparam logic [7:0] FEBP_RAM_EMUL_MASK   = 8'h08;

  // ----------------------------------------------------------------------
  // Flash read-protected address ranges.
  // ----------------------------------------------------------------------
  localparam logic [23:0] FEBP_LOW_AREA_FIRST  = 24'h00_0000;
  localparam logic [23:0] FEBP_LOW_AREA_LAST   = 24'h03_FFFF;
  localparam logic [23:0] FEBP_HIGH_AREA_FIRST = 24'h04_0000;
  localparam logic [23:0] FEBP_HIGH_AREA_LAST  = 24'h07_FFFF;

  // Operating modes that enable the on-chip flash.
  localparam logic [2:0]  FEBP_MODE_FLASH_A    = 3'h6;
  localparam logic [2:0]  FEBP_MODE_FLASH_B    = 3'h7;

  // Register bus request carried as one bundle.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } febp_bus_t;

  // Flash operation state.
  typedef enum logic [1:0] {
    FEBP_IDLE,
    FEBP_PROGRAM,
    FEBP_ERASE
  } febp_state_t;

endpackage : febp_pkg

// [hw/febp_reset_sync.sv]
`timescale 1ns/1ns
`default_nettype none

// Releases the asynchronous reset through two flip-flops.
module febp_reset_sync
(
  input  wire logic clk,
  input  wire logic rst_n,
  output var  logic rstSync_n
);

  logic stage_reg;

  // ----------------------------------------------------------------------
  // Synchroniser.
  // ----------------------------------------------------------------------

  // Assert at once, release after two edges.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_reg <= 1'b0;
      rstSync_n <= 1'b0;
    end
    else
    begin
      stage_reg <= 1'b1;
      rstSync_n <= stage_reg;
    end
  end

endmodule : febp_reset_sync

`default_nettype wire

// [hw/febp_flash_erase_block_protect.sv]
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module febp_flash_erase_block_protect
  import febp_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [3:0]              regAddr,
  input  wire logic [7:0]              regWdata,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output var  logic [7:0]              regRdata,
  input  wire logic                    flashWriteEnablePin,
  input  wire logic [2:0]              opMode,
  input  wire logic                    standby,
  input  wire logic [23:0]             flashReadAddr,
  input  wire logic                    flashReadReq,
  output logic                         flashReadBlocked,
  output logic                         userProgramMode,
  output logic                         ramOverlapActive,
  output logic [FEBP_BLOCKS-1:0]       eraseAllowed,
  output logic                         programActive,
  output logic                         eraseActive
);

  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  febp_bus_t                bus;
  febp_state_t              state_reg;
  febp_state_t              state_next;
  logic                     rstSync_n;
  logic [7:0]               ctrlOne_reg;
  logic [7:0]               ctrlOne_next;
  logic [7:0]               ctrlTwo_reg;
  logic [7:0]               ctrlTwo_next;
  logic [7:0]               selLow_reg;
  logic [7:0]               selLow_next;
  logic [7:0]               selHigh_reg;
  logic [7:0]               selHigh_next;
  logic [7:0]               ramEmul_reg;
  logic [7:0]               ramEmul_next;
  logic [7:0]               rdata_next;
  logic                     flashEnabled;
  logic                     swEnable;
  logic                     selClear;
  logic                     protectedSw;
  logic [FEBP_BLOCKS-1:0]   selAll;
  logic [3:0]               selCount;

  // ----------------------------------------------------------------------
  // Reset release.
  // ----------------------------------------------------------------------
  febp_reset_sync u_reset_sync
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .rstSync_n (rstSync_n)
  );

  // Bundle the register port.
  assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // ----------------------------------------------------------------------
  // Mode and protection decode.
  // ----------------------------------------------------------------------

  // Flash is enabled only in the two flash modes; user program mode needs the pin.
  assign flashEnabled    = (opMode == FEBP_MODE_FLASH_A) || (opMode == FEBP_MODE_FLASH_B);
  assign userProgramMode = flashEnabled && flashWriteEnablePin;
  assign swEnable        = ctrlOne_reg[FEBP_BIT_SWE_LOW] | ctrlOne_reg[FEBP_BIT_SWE_HIGH];
  assign selClear        = standby || !flashWriteEnablePin || !swEnable;
  assign selAll          = {selHigh_reg[3:0], selLow_reg};
  assign protectedSw     = !userProgramMode || !swEnable || (selAll == '0
                           && ctrlOne_reg[FEBP_BIT_ERASE]) || ramEmul_reg[FEBP_BIT_RAM_OVL];
  assign ramOverlapActive = ramEmul_reg[FEBP_BIT_RAM_OVL];

  // One erase strobe per selected block, only while erasing.
  genvar gi;
  generate
    for (gi = 0; gi < FEBP_BLOCKS; gi++)
    begin : g_erase
      assign eraseAllowed[gi] = selAll[gi] && (state_reg == FEBP_ERASE);
    end
  endgenerate

  assign programActive = (state_reg == FEBP_PROGRAM);
  assign eraseActive   = (state_reg == FEBP_ERASE);

  // Reads are blocked in the area whose software enable is set.
  always_comb
  begin
    flashReadBlocked = 1'b0;
    if (flashReadReq && ctrlOne_reg[FEBP_BIT_SWE_LOW]
        && flashReadAddr >= FEBP_LOW_AREA_FIRST && flashReadAddr <= FEBP_LOW_AREA_LAST)
    begin
      flashReadBlocked = 1'b1;
    end
    if (flashReadReq && ctrlOne_reg[FEBP_BIT_SWE_HIGH]
        && flashReadAddr >= FEBP_HIGH_AREA_FIRST && flashReadAddr <= FEBP_HIGH_AREA_LAST)
    begin
      flashReadBlocked = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Register next values.
  // ----------------------------------------------------------------------

  // Counts set select bits after the write has been merged.
  function automatic logic [3:0] count_bits(input logic [FEBP_BLOCKS-1:0] v);
    logic [3:0] n;
    n = '0;
    for (int i = 0; i < FEBP_BLOCKS; i++)
    begin
      n = n + {3'b000, v[i]};
    end
    return n;
  endfunction : count_bits

  // Computes the control, select and RAM overlap register next values.
  always_comb
  begin
    ctrlOne_next = ctrlOne_reg;
    ctrlTwo_next = ctrlTwo_reg;
    selLow_next  = selLow_reg;
    selHigh_next = selHigh_reg;
    ramEmul_next = ramEmul_reg;
    if (bus.wr)
    begin
      unique case (bus.addr)
        FEBP_ADDR_CTRL_ONE: ctrlOne_next = bus.wdata & FEBP_CTRL_ONE_MASK;
        FEBP_ADDR_SEL_LOW:
        begin
          if (flashEnabled)
          begin
            selLow_next = bus.wdata;
          end
        end
        FEBP_ADDR_SEL_HIGH:
        begin
          if (flashEnabled)
          begin
            selHigh_next = bus.wdata & FEBP_SEL_HIGH_MASK;
          end
        end
        FEBP_ADDR_RAM_EMUL: ramEmul_next = bus.wdata & FEBP_RAM_EMUL_MASK;
        default: ;
      endcase
    end
    // Request bits are dropped while protection holds.
    if (protectedSw)
    begin
      ctrlOne_next[FEBP_BIT_PROG]  = 1'b0;
      ctrlOne_next[FEBP_BIT_ERASE] = 1'b0;
    end
    if (standby)
    begin
      ctrlOne_next = FEBP_RESET_BYTE;
      ctrlTwo_next = FEBP_RESET_BYTE;
    end
    selCount = count_bits({selHigh_next[3:0], selLow_next});
    if (selCount > 4'h1 || selClear)
    begin
      selLow_next  = FEBP_RESET_BYTE;
      selHigh_next = FEBP_RESET_BYTE;
    end
    ctrlTwo_next[FEBP_BIT_PROG]  = (state_next == FEBP_PROGRAM);
    ctrlTwo_next[FEBP_BIT_ERASE] = (state_next == FEBP_ERASE);
  end

  // ----------------------------------------------------------------------
  // Read data.
  // ----------------------------------------------------------------------

  // Selects the read data; the select registers read zero while flash is off.
  always_comb
  begin
    rdata_next = FEBP_RESET_BYTE;
    if (bus.rd)
    begin
      unique case (bus.addr)
        FEBP_ADDR_CTRL_ONE: rdata_next = ctrlOne_reg;
        FEBP_ADDR_CTRL_TWO: rdata_next = ctrlTwo_reg;
        FEBP_ADDR_SEL_LOW:  rdata_next = flashEnabled ? selLow_reg : FEBP_RESET_BYTE;
        FEBP_ADDR_SEL_HIGH: rdata_next = flashEnabled ? selHigh_reg : FEBP_RESET_BYTE;
        FEBP_ADDR_RAM_EMUL: rdata_next = ramEmul_reg;
        default:            rdata_next = FEBP_RESET_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Program and erase state.
  // ----------------------------------------------------------------------

  // Enters a mode only from an unprotected request bit.
  always_comb
  begin
    state_next = FEBP_IDLE;
    if (!protectedSw && !standby)
    begin
      if (ctrlOne_reg[FEBP_BIT_ERASE] && selAll != '0)
      begin
        state_next = FEBP_ERASE;
      end
      else if (ctrlOne_reg[FEBP_BIT_PROG])
      begin
        state_next = FEBP_PROGRAM;
      end
    end
  end

  // Registers the operation state and its status copy; reset enters the idle state.
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      state_reg   <= FEBP_IDLE;
      ctrlTwo_reg <= FEBP_RESET_BYTE;
    end
    else
    begin
      state_reg   <= state_next;
      ctrlTwo_reg <= ctrlTwo_next;
    end
  end

  // Registers the request and software-enable bits.
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      ctrlOne_reg <= FEBP_RESET_BYTE;
    end
    else
    begin
      ctrlOne_reg <= ctrlOne_next;
    end
  end

  // Registers the two block-select registers.
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      selLow_reg  <= FEBP_RESET_BYTE;
      selHigh_reg <= FEBP_RESET_BYTE;
    end
    else
    begin
      selLow_reg  <= selLow_next;
      selHigh_reg <= selHigh_next;
    end
  end

  // Registers the RAM overlap control.
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      ramEmul_reg <= FEBP_RESET_BYTE;
    end
    else
    begin
      ramEmul_reg <= ramEmul_next;
    end
  end

  // Registers the read data, which stands for one cycle only.
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      regRdata <= FEBP_RESET_BYTE;
    end
    else
    begin
      regRdata <= rdata_next;
    end
  end

endmodule : febp_flash_erase_block_protect

`default_nettype wire

// [verification/febp_properties.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// Protection checker
// ----------------------------------------------------------------------
module febp_properties
  import febp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  regAddr,
  input wire logic        regRd,
  input wire logic [7:0]  regRdata,
  input wire logic        flashWriteEnablePin,
  input wire logic [2:0]  opMode,
  input wire logic        standby,
  input wire logic [23:0] flashReadAddr,
  input wire logic        flashReadBlocked,
  input wire logic        userProgramMode,
  input wire logic        ramOverlapActive,
  input wire logic [11:0] eraseAllowed,
  input wire logic        programActive,
  input wire logic        eraseActive
);
  // All checks share the one system clock and its reset.
  default clocking cbk @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_rdHigh;
    $past(regRd) && $past(regAddr) == FEBP_ADDR_SEL_HIGH |-> regRdata[7:4] == 4'h0;
  endproperty
  a_rdHigh: assert property (p_rdHigh) else $error("upper select bits read set");
  property p_rdOff;
    $past(regRd) && $past(regAddr[3:1]) == 3'h1 && $past(opMode[2:1]) != 2'b11
      |-> regRdata == 8'h00;
  endproperty
  a_rdOff: assert property (p_rdOff) else $error("select read nonzero, flash off");
  property p_upm;
    userProgramMode == (opMode[2:1] == 2'b11 && flashWriteEnablePin);
  endproperty
  a_upm: assert property (p_upm) else $error("user program mode wrong");
  property p_oneHot;
    $onehot0(eraseAllowed);
  endproperty
  a_oneHot: assert property (p_oneHot) else $error("several blocks erasable");
  property p_eraseGate;
    eraseAllowed != 12'h000 |-> eraseActive;
  endproperty
  a_eraseGate: assert property (p_eraseGate) else $error("erase allowed while idle");
  property p_progCause;
    $rose(programActive) |-> $past(userProgramMode, 2);
  endproperty
  a_progCause: assert property (p_progCause) else $error("program while protected");
  property p_ovl;
    $rose(eraseActive) |-> !$past(ramOverlapActive, 2);
  endproperty
  a_ovl: assert property (p_ovl) else $error("erase under overlap");
  property p_stby;
    standby ##1 standby |=> !programActive && !eraseActive;
  endproperty
  a_stby: assert property (p_stby) else $error("operation in standby");
  property p_pin;
    !flashWriteEnablePin [*2] |=> eraseAllowed == 12'h000;
  endproperty
  a_pin: assert property (p_pin) else $error("erase allowed, pin low");
  property p_area;
    flashReadBlocked |-> flashReadAddr <= FEBP_HIGH_AREA_LAST;
  endproperty
  a_area: assert property (p_area) else $error("read blocked outside areas");

  c_erase: cover property ($rose(eraseActive));
  c_prog: cover property ($rose(programActive));
  c_block: cover property (flashReadBlocked);
endmodule : febp_properties

bind febp_flash_erase_block_protect febp_properties u_props (.clk, .rst_n, .regAddr,
  .regRd, .regRdata, .flashWriteEnablePin, .opMode, .standby, .flashReadAddr,
  .flashReadBlocked, .userProgramMode, .ramOverlapActive, .eraseAllowed,
  .programActive, .eraseActive);
`default_nettype wire

// [verification/febp_flash_erase_block_protect_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module febp_flash_erase_block_protect_bench
  import febp_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic        pin = 1'b0, standby = 1'b0, rdReq = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [2:0]  opMode = 3'h0;
  logic [7:0]  regWdata = 8'h00, regRdata;
  logic [23:0] rdAddr = 24'h00_0000;
  logic [11:0] eraseAllowed;
  logic        blocked, upm, ovl, progAct, eraseAct;
  int          errors = 0, checks_done = 0;

  // The clock toggles every 5 ns, giving a period of 10 ns.
  always #5 clk = ~clk;

  febp_flash_erase_block_protect u_dut (.clk, .rst_n, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .flashWriteEnablePin(pin), .opMode, .standby,
    .flashReadAddr(rdAddr), .flashReadReq(rdReq), .flashReadBlocked(blocked),
    .userProgramMode(upm), .ramOverlapActive(ovl), .eraseAllowed,
    .programActive(progAct), .eraseActive(eraseAct));

  // ----------------------------------------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(24'(regRdata), 24'(e));
  endtask : rd
  task automatic area(input logic [23:0] a, input logic e);
    @(posedge clk);
    rdReq <= 1'b1;
    rdAddr <= a;
    #1;
    chk(24'(blocked), 24'(e));
  endtask : area

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_mode;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      opMode <= i[2:0];
      pin <= i[3];
      #1;
      chk(24'(upm), 24'(i[3] && i[2:1] == 2'b11));
    end
  endtask : t_mode
  task automatic t_select;
    wr(FEBP_ADDR_CTRL_ONE, 8'h40);
    wr(FEBP_ADDR_SEL_LOW, 8'h80);
    rd(FEBP_ADDR_SEL_LOW, 8'h80);
    wr(FEBP_ADDR_SEL_HIGH, 8'h01);
    rd(FEBP_ADDR_SEL_LOW, 8'h00);
    rd(FEBP_ADDR_SEL_HIGH, 8'h00);
    wr(FEBP_ADDR_SEL_HIGH, 8'hF4);
    rd(FEBP_ADDR_SEL_HIGH, 8'h04);
  endtask : t_select
  task automatic t_erase;
    wr(FEBP_ADDR_CTRL_ONE, 8'h42);
    @(posedge clk);
    #1;
    chk(24'(eraseAllowed), 24'h00_0400);
    chk(24'(eraseAct), 24'h1);
    rd(FEBP_ADDR_CTRL_TWO, 8'h02);
    wr(FEBP_ADDR_CTRL_ONE, 8'h40);
  endtask : t_erase
  // The bench plays control software that runs from on-chip RAM.
  task automatic t_protect;
    wr(FEBP_ADDR_RAM_EMUL, 8'h08);
    #1;
    chk(24'(ovl), 24'h1);
    wr(FEBP_ADDR_CTRL_ONE, 8'h41);
    rd(FEBP_ADDR_CTRL_ONE, 8'h40);
    chk(24'(progAct), 24'h0);
    wr(FEBP_ADDR_RAM_EMUL, 8'h00);
    wr(FEBP_ADDR_CTRL_ONE, 8'h41);
    @(posedge clk);
    #1;
    chk(24'(progAct), 24'h1);
    wr(FEBP_ADDR_CTRL_ONE, 8'h40);
  endtask : t_protect
  task automatic t_disabled;
    @(posedge clk);
    opMode <= 3'h3;
    rd(FEBP_ADDR_SEL_HIGH, 8'h00);
    wr(FEBP_ADDR_SEL_HIGH, 8'h08);
    opMode <= 3'h7;
    rd(FEBP_ADDR_SEL_HIGH, 8'h04);
  endtask : t_disabled
  task automatic t_area;
    area(FEBP_LOW_AREA_LAST, 1'b1);
    area(FEBP_HIGH_AREA_FIRST, 1'b0);
    wr(FEBP_ADDR_CTRL_ONE, 8'h80);
    area(FEBP_LOW_AREA_FIRST, 1'b0);
    area(FEBP_HIGH_AREA_LAST, 1'b1);
    area(24'h08_0000, 1'b0);
  endtask : t_area
  task automatic t_clear;
    @(posedge clk);
    pin <= 1'b0;
    @(posedge clk);
    pin <= 1'b1;
    rd(FEBP_ADDR_SEL_HIGH, 8'h00);
    wr(FEBP_ADDR_CTRL_ONE, 8'h40);
    wr(FEBP_ADDR_SEL_LOW, 8'h02);
    wr(FEBP_ADDR_CTRL_ONE, 8'h00);
    rd(FEBP_ADDR_SEL_LOW, 8'h00);
    wr(FEBP_ADDR_CTRL_ONE, 8'hC0);
    standby <= 1'b1;
    repeat (2) @(posedge clk);
    standby <= 1'b0;
    rd(FEBP_ADDR_CTRL_ONE, 8'h00);
  endtask : t_clear
  // Erase requests die without a selected block, even with software enable set.
  task automatic t_guard;
    wr(FEBP_ADDR_CTRL_ONE, 8'h42);
    rd(FEBP_ADDR_CTRL_ONE, 8'h40);
    wr(FEBP_ADDR_CTRL_ONE, 8'h42);
    rd(FEBP_ADDR_CTRL_ONE, 8'h40);
    chk(24'(eraseAct), 24'h0);
    @(posedge clk);
    rdReq <= 1'b0;
    rdAddr <= FEBP_LOW_AREA_FIRST;
    #1;
    chk(24'(blocked), 24'h0);
    wr(FEBP_ADDR_CTRL_ONE, 8'h00);
  endtask : t_guard
  // A reset in mid-run clears the control and select registers again.
  task automatic t_reset;
    wr(FEBP_ADDR_CTRL_ONE, 8'hC0);
    wr(FEBP_ADDR_SEL_LOW, 8'h01);
    rd(FEBP_ADDR_SEL_LOW, 8'h01);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(FEBP_ADDR_CTRL_ONE, 8'h00);
    rd(FEBP_ADDR_SEL_LOW, 8'h00);
  endtask : t_reset

  // ----------------------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------------------------------------
  task automatic report_and_stop;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Resets the block, then runs every scenario in turn.
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(FEBP_ADDR_CTRL_ONE, 8'h00);
    rd(FEBP_ADDR_SEL_LOW, 8'h00);
    rd(FEBP_ADDR_SEL_HIGH, 8'h00);
    rd(4'hF, 8'h00);
    t_mode;
    t_select;
    t_erase;
    t_protect;
    t_disabled;
    t_area;
    t_clear;
    t_guard;
    t_reset;
    report_and_stop;
  end

  // Cuts a hang short well beyond the 130 or so cycles the run needs.
  initial
  begin
    #20000;
    errors++;
    report_and_stop;
  end
endmodule : febp_flash_erase_block_protect_bench
`default_nettype wire
